// file: hdl/ams_axis_move_sequencer.sv
// Axis move sequencer: move buffers, end modify, linked start, position tracking.
`timescale 1ns/1ps
// What this block does
// - Option 1 waits for link registration event.
// - Option 2 starts at absolute link position.
// - Option 4 repeats both ways until cancelled.
// - Options 5 and 6 combine start with repeat.
// - Summed phases accepted as one linked move.
// - Modify replaces target of running linear move.
// - Modify without linear move acts as absolute.
// - End position reports current move end.
// - Measured position from encoder, zero at reset.
// - Measured position wraps per repeat settings.
// - Measured speed is per-period change scaled.
// - Current move type uses documented codes.
// - Move type stays non-idle at zero speed.
// - Next move type reports buffered move.
// - Cancel one clears next move buffer.
// - Move type registers ignore writes.
// - Offset shifts demand and measured equally, but a started move sets demand back to its target next period.
// - Offset applied next period, then reads zero.
// - Device clears offset when loaded.
// - Oversized accel plus decel spans scaled down.
module ams_axis_move_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] enc_edges,
  input  wire logic        link_regist,
  input  wire logic [31:0] link_position,
  input  wire logic        move_done,
  output logic             servo_tick
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [15:0] enc_s1, enc_s2;
  logic        reg_s1, reg_s2, done_s1, done_s2, done_s3, done_rise;
  logic [31:0] lpos_s1, lpos_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {enc_s2, enc_s1}            <= 32'h00000000;
      {reg_s2, reg_s1}            <= 2'h0;
      {done_s3, done_s2, done_s1} <= 3'h0;
      {lpos_s2, lpos_s1}          <= 64'h0000000000000000;
    end else begin
      {enc_s2, enc_s1}            <= {enc_s1, enc_edges};
      {reg_s2, reg_s1}            <= {reg_s1, link_regist};
      {done_s3, done_s2, done_s1} <= {done_s2, done_s1, move_done};
      {lpos_s2, lpos_s1}          <= {lpos_s1, link_position};
    end
  end
  assign done_rise = done_s2 && !done_s3;

  // ----------------------------------------------------------------------
  // Servo period timer
  // ----------------------------------------------------------------------
  localparam logic [31:0] SERVO_LAST = 32'(ams_pkg::SERVO_CYCLES - 1);
  logic [31:0] tick_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h00000000;
    end else if (tick_cnt == SERVO_LAST) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end
  assign servo_tick = (tick_cnt == SERVO_LAST);

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic wr_en;
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] off, input logic en);
    is_wr = en && (a == off);
  endfunction

  logic [31:0] a_pos, a_dist, a_ldst, a_lacc, a_ldec, a_lpos;
  logic [2:0]  a_lopt;
  logic [31:0] repeat_distance, rep_opt, units, offset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_pos    <= 32'h00000000;
      a_dist   <= 32'h00000000;
      a_ldst   <= 32'h00000000;
      a_lacc   <= 32'h00000000;
      a_ldec   <= 32'h00000000;
      a_lpos   <= 32'h00000000;
      a_lopt   <= 3'h0;
      repeat_distance <= 32'h00000000;
      rep_opt  <= 32'h00000000;
      units    <= ams_pkg::UNITS_RST;
    end else begin
      if (is_wr(paddr, ams_pkg::OFF_ARG_POS, wr_en)) a_pos <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_ARG_DIST, wr_en)) a_dist <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_ARG_LDST, wr_en)) a_ldst <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_ARG_LACC, wr_en)) a_lacc <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_ARG_LDEC, wr_en)) a_ldec <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_ARG_LPOS, wr_en)) a_lpos <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_ARG_LOPT, wr_en)) a_lopt <= pwdata[2:0];
      if (is_wr(paddr, ams_pkg::OFF_REPEAT_DISTANCE, wr_en)) repeat_distance <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_REP_OPT, wr_en)) rep_opt <= pwdata;
      if (is_wr(paddr, ams_pkg::OFF_UNITS, wr_en) && pwdata != 32'h00000000) units <= pwdata;
    end
  end

  logic       cmd_wr;
  logic [3:0] cmd;
  assign cmd_wr = is_wr(paddr, ams_pkg::OFF_CMD, wr_en);
  assign cmd    = pwdata[3:0];

  // ----------------------------------------------------------------------
  // Measured position, demand position, offset
  // ----------------------------------------------------------------------
  logic [31:0] measured_position, demand_position, prev_measured_position, measured_speed, edge_acc;
  logic [31:0] endpos, move_start;
  logic [31:0] next_edge_acc, next_measured_position;

  // Edges left over from a partial unit carry into the next period.
  always_comb begin
    next_edge_acc = edge_acc + {{16{enc_s2[15]}}, enc_s2};
    next_measured_position     = measured_position + 32'($signed(next_edge_acc) / $signed(units));
    next_edge_acc = 32'($signed(next_edge_acc) % $signed(units));
    next_measured_position     = next_measured_position + offset;
    if (repeat_distance != 32'h00000000) begin
      if (rep_opt[0]) begin
        if ($signed(next_measured_position) >= $signed(repeat_distance)) next_measured_position = next_measured_position - repeat_distance;
        else if ($signed(next_measured_position) < 0) next_measured_position = next_measured_position + repeat_distance;
      end else begin
        if ($signed(next_measured_position) >= $signed(repeat_distance)) next_measured_position = next_measured_position - (repeat_distance << 1);
        else if ($signed(next_measured_position) < -$signed(repeat_distance)) next_measured_position = next_measured_position + (repeat_distance << 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      measured_position      <= 32'h00000000;
      prev_measured_position <= 32'h00000000;
      edge_acc  <= 32'h00000000;
      measured_speed    <= 32'h00000000;
    end else if (cmd_wr && cmd == ams_pkg::CMD_POSITION_DEFINE) begin
      measured_position      <= a_pos;
      prev_measured_position <= a_pos;
    end else if (servo_tick) begin
      measured_position      <= next_measured_position;
      edge_acc  <= next_edge_acc;
      prev_measured_position <= next_measured_position;
      // Offset shift excluded so a define or offset does not show as speed.
      measured_speed    <= 32'((next_measured_position - offset - measured_position) * ams_pkg::SPEED_SCALE);
    end
  end

  // A write landing on the load tick is kept for the following period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset <= 32'h00000000;
    end else if (is_wr(paddr, ams_pkg::OFF_OFFSET, wr_en)) begin
      offset <= pwdata;
    end else if (servo_tick) begin
      offset <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Linked span scaling
  // ----------------------------------------------------------------------
  logic [31:0] lacc_s, ldec_s;
  logic [63:0] span_sum;

  always_comb begin
    span_sum = {32'h00000000, a_lacc} + {32'h00000000, a_ldec};
    lacc_s   = a_lacc;
    ldec_s   = a_ldec;
    if (span_sum > {32'h00000000, a_ldst} && span_sum != 64'h0) begin
      lacc_s = 32'(({32'h00000000, a_lacc} * {32'h00000000, a_ldst}) / span_sum);
      ldec_s = a_ldst - lacc_s;
    end
  end

  // ----------------------------------------------------------------------
  // Move buffers
  // ----------------------------------------------------------------------
  ams_pkg::ams_move_t cur, nxt, new_mv;
  logic               cur_run, nxt_full, have_new;
  logic               link_go;

  always_comb begin
    new_mv   = '0;
    have_new = 1'b0;
    if (cmd_wr) begin
      if (cmd == ams_pkg::CMD_REL) begin
        have_new      = 1'b1;
        new_mv.current_move_type  = ams_pkg::MT_REL;
        new_mv.target = endpos + a_dist;
      end else if (cmd == ams_pkg::CMD_ABS ||
                   (cmd == ams_pkg::CMD_MODIFY && !(cur_run &&
                    (cur.current_move_type == ams_pkg::MT_REL || cur.current_move_type == ams_pkg::MT_ABS)))) begin
        have_new      = 1'b1;
        new_mv.current_move_type  = ams_pkg::MT_ABS;
        new_mv.target = a_pos;
      end else if (cmd == ams_pkg::CMD_LINK) begin
        have_new      = 1'b1;
        new_mv.current_move_type  = ams_pkg::MT_LINK;
        new_mv.lopt   = a_lopt;
        new_mv.target = endpos + a_dist;
        new_mv.ldist  = a_ldst;
        new_mv.lacc   = lacc_s;
        new_mv.ldec   = ldec_s;
        new_mv.lpos   = a_lpos;
      end
    end
  end

  // Linked start gate: registration, link position, or immediate.
  always_comb begin
    link_go = 1'b1;
    if (cur.lopt[1:0] == ams_pkg::LOPT_REG[1:0]) link_go = reg_s2;
    else if (cur.lopt[1:0] == ams_pkg::LOPT_POS[1:0]) begin
      link_go = ($signed(lpos_s2) >= $signed(cur.lpos));
    end
  end

  logic link_wait;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur       <= '0;
      nxt       <= '0;
      cur_run   <= 1'b0;
      nxt_full  <= 1'b0;
      link_wait <= 1'b0;
      endpos    <= 32'h00000000;
      move_start <= 32'h00000000;
    end else begin
      if (cmd_wr && cmd == ams_pkg::CMD_MODIFY && cur_run &&
          (cur.current_move_type == ams_pkg::MT_REL || cur.current_move_type == ams_pkg::MT_ABS)) begin
        cur.target <= a_pos;
        endpos     <= a_pos;
      end else if (cmd_wr && cmd == ams_pkg::CMD_POSITION_DEFINE && !cur_run) begin
        endpos <= a_pos;
      end else if (servo_tick && offset != 32'h00000000) begin
        endpos <= endpos + offset;
      end
      if (link_wait && link_go) link_wait <= 1'b0;
      if (cmd_wr && cmd == ams_pkg::CMD_CANCEL1) begin
        nxt_full <= 1'b0;
        nxt      <= '0;
      end else if (cmd_wr && cmd == ams_pkg::CMD_CANCEL0) begin
        cur_run <= 1'b0;
        cur     <= '0;
      end else if (have_new && !cur_run) begin
        cur       <= new_mv;
        cur_run   <= 1'b1;
        endpos    <= new_mv.target;
        move_start <= endpos;
        link_wait <= (new_mv.current_move_type == ams_pkg::MT_LINK) && (new_mv.lopt[1:0] != 2'b00);
      end else if (have_new && !nxt_full) begin
        nxt      <= new_mv;
        nxt_full <= 1'b1;
      end else if (cur_run && done_rise && !link_wait) begin
        if (cur.current_move_type == ams_pkg::MT_LINK && cur.lopt[2] &&
            !rep_opt[ams_pkg::REP_CANCEL_BIT]) begin
          cur.target <= move_start;
          endpos     <= move_start;
          move_start <= endpos;
        end else if (nxt_full) begin
          cur       <= nxt;
          endpos    <= nxt.target;
          move_start <= endpos;
          nxt_full  <= 1'b0;
          nxt       <= '0;
          link_wait <= (nxt.current_move_type == ams_pkg::MT_LINK) && (nxt.lopt[1:0] != 2'b00);
        end else begin
          cur_run <= 1'b0;
          cur     <= '0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      demand_position <= 32'h00000000;
    end else if (cmd_wr && cmd == ams_pkg::CMD_POSITION_DEFINE) begin
      demand_position <= a_pos;
    end else if (servo_tick) begin
      demand_position <= (cur_run && !link_wait ? cur.target : demand_position) + offset;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Move type offsets have no write path at all, so writes there are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == ams_pkg::OFF_MEASURED_POSITION) prdata <= measured_position;
      else if (paddr == ams_pkg::OFF_MEASURED_SPEED) prdata <= measured_speed;
      else if (paddr == ams_pkg::OFF_DEMAND_POSITION) prdata <= demand_position;
      else if (paddr == ams_pkg::OFF_ENDPOS) prdata <= endpos;
      else if (paddr == ams_pkg::OFF_CURRENT_MOVE_TYPE) prdata <= {24'h000000, cur.current_move_type};
      else if (paddr == ams_pkg::OFF_NEXT_MOVE_TYPE) prdata <= {24'h000000, nxt.current_move_type};
      else if (paddr == ams_pkg::OFF_OFFSET) prdata <= offset;
      else if (paddr == ams_pkg::OFF_REPEAT_DISTANCE) prdata <= repeat_distance;
      else if (paddr == ams_pkg::OFF_REP_OPT) prdata <= rep_opt;
      else if (paddr == ams_pkg::OFF_UNITS) prdata <= units;
      else if (paddr == ams_pkg::OFF_ARG_LOPT) prdata <= {29'h0, a_lopt};
      else if (paddr == ams_pkg::OFF_LSPAN) prdata <= {ldec_s[15:0], lacc_s[15:0]};
      else prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb_chk @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_offset_clear;
    servo_tick && !is_wr(paddr, ams_pkg::OFF_OFFSET, wr_en) |=> offset == 32'h00000000;
  endproperty
  a_offset_clear: assert property (p_offset_clear) else $error("offset not cleared");
  property p_cancel_next;
    cmd_wr && cmd == ams_pkg::CMD_CANCEL1 |=> !nxt_full && nxt.current_move_type == ams_pkg::MT_IDLE;
  endproperty
  a_cancel_next: assert property (p_cancel_next) else $error("next buffer kept");
  property p_modify;
    cmd_wr && cmd == ams_pkg::CMD_MODIFY && cur_run && cur.current_move_type == ams_pkg::MT_ABS
    |=> cur.target == $past(a_pos) && endpos == $past(a_pos);
  endproperty
  a_modify: assert property (p_modify) else $error("modify not applied");
  property p_modify_idle;
    cmd_wr && cmd == ams_pkg::CMD_MODIFY && !cur_run |=> cur.current_move_type == ams_pkg::MT_ABS;
  endproperty
  a_modify_idle: assert property (p_modify_idle) else $error("modify not absolute");
  property p_run_type;
    cur_run |-> cur.current_move_type != ams_pkg::MT_IDLE;
  endproperty
  a_run_type: assert property (p_run_type) else $error("idle type while running");
  property p_span;
    span_sum > {32'h00000000, a_ldst}
    |-> lacc_s + ldec_s == a_ldst && lacc_s <= a_lacc && ldec_s <= a_ldec;
  endproperty
  a_span: assert property (p_span) else $error("span not scaled");
  property p_measured_position_tick;
    !servo_tick && !(cmd_wr && cmd == ams_pkg::CMD_POSITION_DEFINE) |=> $stable(measured_position);
  endproperty
  a_measured_position_tick: assert property (p_measured_position_tick) else $error("measured_position moved off tick");
  property p_link_hold;
    link_wait && cur.lopt[1:0] == 2'b01 && !reg_s2 |=> link_wait;
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link started early");
  property p_link_pos_hold;
    link_wait && cur.lopt[1:0] == 2'b10 && $signed(lpos_s2) < $signed(cur.lpos) |=> link_wait;
  endproperty
  a_link_pos_hold: assert property (p_link_pos_hold) else $error("early link start");

endmodule

// file: hdl/ams_pkg.sv
// Shared constants, types and register map of the axis move sequencer.
package ams_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_ARG_POS  = 8'h04;
  localparam logic [7:0] OFF_ARG_DIST = 8'h08;
  localparam logic [7:0] OFF_ARG_LDST = 8'h0C;
  localparam logic [7:0] OFF_ARG_LACC = 8'h10;
  localparam logic [7:0] OFF_ARG_LDEC = 8'h14;
  localparam logic [7:0] OFF_ARG_LPOS = 8'h18;
  localparam logic [7:0] OFF_ARG_LOPT = 8'h1C;
  localparam logic [7:0] OFF_REPEAT_DISTANCE = 8'h20;
  localparam logic [7:0] OFF_REP_OPT  = 8'h24;
  localparam logic [7:0] OFF_UNITS    = 8'h28;
  localparam logic [7:0] OFF_OFFSET   = 8'h2C;
  localparam logic [7:0] OFF_MEASURED_POSITION     = 8'h30;
  localparam logic [7:0] OFF_MEASURED_SPEED   = 8'h34;
  localparam logic [7:0] OFF_DEMAND_POSITION     = 8'h38;
  localparam logic [7:0] OFF_ENDPOS   = 8'h3C;
  localparam logic [7:0] OFF_CURRENT_MOVE_TYPE    = 8'h40;
  localparam logic [7:0] OFF_NEXT_MOVE_TYPE    = 8'h44;
  localparam logic [7:0] OFF_LSPAN    = 8'h48;

  // ----------------------------------------------------------------------
  // Command codes written to the command register
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_REL     = 4'h1;
  localparam logic [3:0] CMD_ABS     = 4'h2;
  localparam logic [3:0] CMD_MODIFY  = 4'h3;
  localparam logic [3:0] CMD_LINK    = 4'h4;
  localparam logic [3:0] CMD_POSITION_DEFINE  = 4'h5;
  localparam logic [3:0] CMD_CANCEL0 = 4'h6;
  localparam logic [3:0] CMD_CANCEL1 = 4'h7;

  // ----------------------------------------------------------------------
  // Move type codes and link options
  // ----------------------------------------------------------------------
  localparam logic [7:0] MT_IDLE   = 8'h00;
  localparam logic [7:0] MT_REL    = 8'h01;
  localparam logic [7:0] MT_ABS    = 8'h02;
  localparam logic [7:0] MT_MODIFY = 8'h05;
  localparam logic [7:0] MT_LINK   = 8'h16;
  localparam logic [2:0] LOPT_REG  = 3'h1;
  localparam logic [2:0] LOPT_POS  = 3'h2;
  localparam logic [2:0] LOPT_REP  = 3'h4;
  localparam int         REP_CANCEL_BIT = 1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SERVO_PERIOD_US = 1000;
  localparam int CLK_NS          = 100;
  localparam int SERVO_CYCLES    = SERVO_PERIOD_US * 1000 / CLK_NS;
  localparam int SPEED_SCALE     = 1000 * 1000 / SERVO_PERIOD_US * 1000 / 1000;
  localparam logic [31:0] UNITS_RST = 32'h00000001;

  // ----------------------------------------------------------------------
  // Move descriptor carried through the move buffers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  current_move_type;
    logic [2:0]  lopt;
    logic [31:0] target;
    logic [31:0] ldist;
    logic [31:0] lacc;
    logic [31:0] ldec;
    logic [31:0] lpos;
  } ams_move_t;

endpackage

// file: testbench/ams_axis_model.sv
// Encoder, link axis and profile generator model facing the sequencer.
`timescale 1ns/1ps
module ams_axis_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        servo_tick,
  input  wire logic [15:0] next_edges,
  input  wire logic        done_req,
  input  wire logic        regist_req,
  output logic      [15:0] enc_edges,
  output logic             link_regist,
  output logic      [31:0] link_position,
  output logic             move_done
);
  logic [2:0] done_cnt;
  logic [2:0] reg_cnt;
  // Edges change just after a tick, so each servo period sees one steady count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_edges     <= 16'h0000;
      link_position <= 32'h00000000;
      done_cnt      <= 3'h0;
      reg_cnt       <= 3'h0;
    end else begin
      if (servo_tick) begin
        enc_edges <= next_edges;
      end
      link_position <= link_position + 32'h00000001;
      done_cnt      <= done_req ? 3'h4 : done_cnt - {2'h0, done_cnt != 3'h0};
      reg_cnt       <= regist_req ? 3'h4 : reg_cnt - {2'h0, reg_cnt != 3'h0};
    end
  end
  // Pulses are stretched so that the two-stage synchronisers cannot miss them.
  assign move_done   = (done_cnt != 3'h0);
  assign link_regist = (reg_cnt != 3'h0);
endmodule

// file: testbench/tb.sv
// Self-checking bench of the axis move sequencer.
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] enc_edges;
  logic        link_regist;
  logic [31:0] link_position;
  logic        move_done;
  logic        servo_tick;
  logic [15:0] next_edges = 16'h0000;
  logic        done_req = 1'b0;
  logic        regist_req = 1'b0;
  int          bad_count = 0;
  int          checked = 0;
  logic [31:0] rd, u, e, p, d, off, dp0, mp0, ld, la;
  logic [2:0]  opts [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  always #50 pclk = ~pclk;

  ams_axis_move_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_edges(enc_edges),
    .link_regist(link_regist), .link_position(link_position),
    .move_done(move_done), .servo_tick(servo_tick));
  ams_axis_model u_model (.pclk(pclk), .presetn(presetn), .servo_tick(servo_tick),
    .next_edges(next_edges), .done_req(done_req), .regist_req(regist_req),
    .enc_edges(enc_edges), .link_regist(link_regist),
    .link_position(link_position), .move_done(move_done));

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; holds the request until pready is seen.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask

  task automatic cmd(input logic [3:0] c);
    wr(ams_pkg::OFF_CMD, {28'h0000000, c});
  endtask

  task automatic pulse(input logic done);
    done_req <= done;
    regist_req <= !done;
    @(posedge pclk);
    done_req <= 1'b0;
    regist_req <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  task automatic wait_tick();
    int n;
    n = 0;
    while (servo_tick !== 1'b1 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 12000) begin
      bad_count++;
      tally_and_finish();
    end
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [31:0] speed_exp(input logic [31:0] dl);
    return dl * (32'd1000000 / ams_pkg::SERVO_PERIOD_US);
  endfunction

  // Oversized spans shrink in proportion so that they sum to the link distance.
  function automatic logic [31:0] span_exp(input logic [31:0] l, input logic [31:0] a);
    logic [31:0] s;
    if (a + a > l) begin
      s = a * l / (a + a);
      return {16'(l - s), s[15:0]};
    end
    return {a[15:0], a[15:0]};
  endfunction

  initial begin
    void'($urandom(37));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ams_pkg::OFF_MEASURED_POSITION, 32'h00000000);
    rdc(ams_pkg::OFF_UNITS, ams_pkg::UNITS_RST);
    wr(ams_pkg::OFF_CURRENT_MOVE_TYPE, 32'h00000005);
    wr(ams_pkg::OFF_NEXT_MOVE_TYPE, 32'h00000002);
    wr(ams_pkg::OFF_MEASURED_POSITION, 32'h00001234);
    rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, {24'h0, ams_pkg::MT_IDLE});
    rdc(ams_pkg::OFF_NEXT_MOVE_TYPE, 32'h00000000);
    rdc(ams_pkg::OFF_MEASURED_POSITION, 32'h00000000);
    rdc(8'h4C, 32'h00000000);
    p = $urandom_range(1000, 1);
    wr(ams_pkg::OFF_ARG_POS, p);
    cmd(ams_pkg::CMD_MODIFY);
    rdc(ams_pkg::OFF_ENDPOS, p);
    rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, {24'h0, ams_pkg::MT_ABS});
    p = p + 32'd500;
    wr(ams_pkg::OFF_ARG_POS, p);
    cmd(ams_pkg::CMD_MODIFY);
    rdc(ams_pkg::OFF_ENDPOS, p);
    d = $urandom_range(300, 1);
    wr(ams_pkg::OFF_ARG_DIST, d);
    cmd(ams_pkg::CMD_REL);
    rdc(ams_pkg::OFF_NEXT_MOVE_TYPE, {24'h0, ams_pkg::MT_REL});
    cmd(ams_pkg::CMD_CANCEL1);
    rdc(ams_pkg::OFF_NEXT_MOVE_TYPE, 32'h00000000);
    cmd(ams_pkg::CMD_REL);
    pulse(1'b1);
    rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, {24'h0, ams_pkg::MT_REL});
    rdc(ams_pkg::OFF_ENDPOS, p + d);
    pulse(1'b1);
    rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, 32'h00000000);
    u = $urandom_range(8, 1);
    e = u * $urandom_range(200, 1);
    wr(ams_pkg::OFF_REPEAT_DISTANCE, 32'h00100000);
    wr(ams_pkg::OFF_UNITS, u);
    next_edges <= e[15:0];
    wait_tick();
    next_edges <= 16'h0000;
    wait_tick();
    rdc(ams_pkg::OFF_MEASURED_POSITION, e / u);
    rdc(ams_pkg::OFF_MEASURED_SPEED, speed_exp(e / u));
    apb(1'b0, ams_pkg::OFF_DEMAND_POSITION, 32'h00000000);
    dp0 = rd;
    apb(1'b0, ams_pkg::OFF_MEASURED_POSITION, 32'h00000000);
    mp0 = rd;
    off = $urandom_range(4000, 1);
    wr(ams_pkg::OFF_OFFSET, off);
    rdc(ams_pkg::OFF_OFFSET, off);
    wait_tick();
    rdc(ams_pkg::OFF_OFFSET, 32'h00000000);
    rdc(ams_pkg::OFF_DEMAND_POSITION, dp0 + off);
    rdc(ams_pkg::OFF_MEASURED_POSITION, mp0 + off);
    foreach (opts[i]) begin
      ld = (i == 0) ? 32'd18 : 32'h100 + $urandom_range(255, 0);
      la = (i == 0) ? 32'd8 : ld;
      d = (i == 0) ? 32'h0000000A : ld / 2;
      wr(ams_pkg::OFF_ARG_DIST, d);
      wr(ams_pkg::OFF_ARG_LDST, ld);
      wr(ams_pkg::OFF_ARG_LACC, la);
      wr(ams_pkg::OFF_ARG_LDEC, la);
      wr(ams_pkg::OFF_ARG_LPOS, link_position + 32'd64);
      wr(ams_pkg::OFF_ARG_LOPT, {29'h0, opts[i]});
      cmd(ams_pkg::CMD_LINK);
      if (opts[i][0]) begin
        pulse(1'b0);
      end
      repeat (100) @(posedge pclk);
      rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, {24'h0, ams_pkg::MT_LINK});
      rdc(ams_pkg::OFF_LSPAN, span_exp(ld, la));
      apb(1'b0, ams_pkg::OFF_ENDPOS, 32'h00000000);
      dp0 = rd;
      pulse(1'b1);
      if (opts[i][2]) begin
        rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, {24'h0, ams_pkg::MT_LINK});
        rdc(ams_pkg::OFF_ENDPOS, dp0 - d);
        wr(ams_pkg::OFF_REP_OPT, 32'h00000002);
        pulse(1'b1);
        wr(ams_pkg::OFF_REP_OPT, 32'h00000000);
      end
      rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, 32'h00000000);
    end
    p = $urandom_range(5000, 1);
    wr(ams_pkg::OFF_ARG_POS, p);
    cmd(ams_pkg::CMD_POSITION_DEFINE);
    rdc(ams_pkg::OFF_MEASURED_POSITION, p);
    rdc(ams_pkg::OFF_DEMAND_POSITION, p);
    cmd(ams_pkg::CMD_ABS);
    rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, {24'h0, ams_pkg::MT_ABS});
    cmd(ams_pkg::CMD_CANCEL0);
    rdc(ams_pkg::OFF_CURRENT_MOVE_TYPE, 32'h00000000);
    tally_and_finish();
  end
endmodule
